// *** hw/scl_clock_gen.sv ***
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module scl_clock_gen
  import scl_gen_pkg::*;
#(
  parameter int DIV_W = 9
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        clkEn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Bus clock pin, open drain
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  // Status towards the rest of the interface
  output logic             sclRun,
  output logic [5:0]       maxHoldCycles,
  output logic             slaveResetN
);

  // The register map and hold bound assume a 9-bit divider
  if (DIV_W != 9) begin : g_bad_div_w
    $error("DIV_W must be 9");
  end

  state_s r, next_r;
  logic   apbWr, apbRd, phaseDone;
  logic [17:0] lowLen, highLen;
  logic [3:0]  nLow, nHigh;

  assign apbWr = psel && penable && pwrite;
  // Read data is loaded in the setup cycle so it stands at the access edge
  assign apbRd = psel && !penable && !pwrite;

  always_comb begin
    case (r.ratio)
      RATIO_ASYMMETRIC: begin nLow = N_ASYM_LOW; nHigh = N_ASYM_HIGH; end
      RATIO_FAST:       begin nLow = N_FAST_LOW; nHigh = N_FAST_HIGH; end
      default:          begin nLow = N_STD_LOW;  nHigh = N_STD_HIGH;  end
    endcase
  end

  always_comb begin
    logic [3:0] idx;
    idx = 4'h0;
    if (r.div < 9'h003) begin
      idx = 4'(r.div[1:0] * 2'h3 + 4'(r.ratio));
      lowLen  = 18'(SMALL_TABLE[idx].low);
      highLen = 18'(SMALL_TABLE[idx].high);
    end else begin
      lowLen  = 18'(nLow)  * (18'(r.div) + 18'h00001);
      highLen = 18'(nHigh) * (18'(r.div) + 18'h00001);
    end
  end

  assign phaseDone = (r.count + 18'h00001) >= ((r.state == ST_LOW) ? lowLen : highLen);

  always_comb begin
    next_r = r;
    next_r.slaveReset = 1'b0;
    // Synchroniser: first stage feeds only the second
    next_r.sclSync = {r.sclSync[0], sclIn};
    if (apbWr) begin
      if (paddr == OFF_CTRL) begin
        next_r.en     = pwdata[CTRL_EN_BIT];
        next_r.master = pwdata[CTRL_MASTER_BIT];
        next_r.ratio  = clock_ratio_select_e'(pwdata[CTRL_RATIO_LSB +: 2]);
        if (!pwdata[CTRL_EN_BIT]) next_r.slaveReset = 1'b1;
      end else if (paddr == OFF_DIV) begin
        next_r.div = pwdata[8:0];
      end
    end
    if (apbRd) begin
      if (paddr == OFF_CTRL) next_r.prdata = {28'h0, r.ratio, r.master, r.en};
      else if (paddr == OFF_DIV) next_r.prdata = {23'h0, r.div};
      else if (paddr == OFF_STATUS) next_r.prdata = {29'h0, r.sclSync[1], r.state};
      else next_r.prdata = 32'h0;
    end
    case (r.state)
      ST_IDLE: begin
        next_r.sclDrive = 1'b0;
        next_r.count    = 18'h0;
        if (r.en && r.master) begin
          next_r.state    = ST_LOW;
          next_r.sclDrive = 1'b1;
        end
      end
      ST_LOW: begin
        next_r.count = r.count + 18'h00001;
        if (phaseDone) begin
          next_r.state    = ST_HIGH;
          next_r.sclDrive = 1'b0;
          next_r.count    = 18'h0;
        end
      end
      // wait out stretching, restart the high count once seen high
      ST_WAIT: begin
        if (r.sclSync[1]) begin
          next_r.state = ST_HIGH;
          next_r.count = 18'h0;
        end
      end
      ST_HIGH: begin
        next_r.count = r.count + 18'h00001;
        // line still low once the synchroniser has caught up
        if (r.count >= 18'h00002 && !r.sclSync[1]) begin
          next_r.state = ST_WAIT;
          next_r.count = 18'h0;
        end else if (phaseDone) begin
          next_r.state    = ST_LOW;
          next_r.sclDrive = 1'b1;
          next_r.count    = 18'h0;
        end
      end
      default: next_r.state = ST_IDLE;
    endcase
    if (!r.en || !r.master) begin
      next_r.state    = ST_IDLE;
      next_r.sclDrive = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      r <= '{en: 1'b0, master: 1'b0, ratio: RATIO_STANDARD, div: DIV_RESET, state: ST_IDLE,
             count: 18'h0, sclSync: 2'h3, sclDrive: 1'b0, prdata: 32'h0, slaveReset: 1'b0};
    end else if (clkEn) begin
      r <= next_r;
    end
  end

  assign prdata  = r.prdata;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign sclOut  = 1'b0;
  assign sclOe   = r.sclDrive;
  assign sclRun  = (r.state != ST_IDLE);
  assign maxHoldCycles = HOLD_BASE + 6'(r.div);
  assign slaveResetN   = !r.slaveReset && r.en;

  property p_low_len;
    @(posedge clk) disable iff (!arst_n)
      (clkEn && r.state == ST_LOW && phaseDone) |-> (r.count + 18'h1 == lowLen);
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase length wrong");

  property p_wait_high;
    @(posedge clk) disable iff (!arst_n)
      (clkEn && r.state == ST_WAIT && !r.sclSync[1]) |=> (r.state == ST_WAIT || !r.en || !r.master);
  endproperty
  a_wait_high: assert property (p_wait_high) else $error("stretch not honoured");

  property p_hold;
    @(posedge clk) disable iff (!arst_n) maxHoldCycles == 6'(r.div) + 6'h04;
  endproperty
  a_hold: assert property (p_hold) else $error("hold bound wrong");

  property p_div0;
    @(posedge clk) disable iff (!arst_n) (r.div == 9'h0 && r.ratio == RATIO_FAST) |-> lowLen == 18'd14;
  endproperty
  a_div0: assert property (p_div0) else $error("div0 fast low wrong");

  property p_div2;
    @(posedge clk) disable iff (!arst_n) (r.div == 9'h2 && r.ratio == RATIO_FAST) |-> highLen == 18'd21;
  endproperty
  a_div2: assert property (p_div2) else $error("div2 fast high wrong");

  property p_ratio;
    @(posedge clk) disable iff (!arst_n) (r.div == 9'h9 && r.ratio == RATIO_ASYMMETRIC) |-> lowLen == 18'd60;
  endproperty
  a_ratio: assert property (p_ratio) else $error("asym ratio wrong");

  property p_drive;
    @(posedge clk) disable iff (!arst_n) (r.state == ST_LOW) |-> sclOe;
  endproperty
  a_drive: assert property (p_drive) else $error("scl not pulled low");

  property p_dis;
    @(posedge clk) disable iff (!arst_n) (clkEn && apbWr && paddr == OFF_CTRL && !pwdata[0]) |=> !slaveResetN;
  endproperty
  a_dis: assert property (p_dis) else $error("slave reset missing");

endmodule

// *** hw/scl_gen_pkg.sv ***
// Functional notes
// - Clearing the interface enable returns the slave logic to a known state.
// - As master, SCL comes from dividing the peripheral clock.
// - SCL frequency is one over low plus high period.
// - From divider 3 up, each unstretched phase lasts ratio count times divider plus one cycles.
// - Divider 0 phases: 7/7, 9/6, 14/9 cycles per ratio.
// - Divider 1: 10/10, 14/8, 24/14; divider 2: 15/15, 21/12, 36/21.
// - Ratio select picks standard 4:4, asymmetric 6:3 or fast 11:6.
// - Maximum data hold time is four plus divider cycles; maxHoldCycles is 6 bits wide and wraps from divider 60 up.
package scl_gen_pkg;

  typedef enum logic [1:0] {
    RATIO_STANDARD   = 2'h0,
    RATIO_ASYMMETRIC = 2'h1,
    RATIO_FAST       = 2'h2
  } clock_ratio_select_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_LOW  = 2'h1,
    ST_WAIT = 2'h2,
    ST_HIGH = 2'h3
  } scl_state_e;

  // APB map
  localparam logic [11:0] OFF_CTRL   = 12'h000;
  localparam logic [11:0] OFF_DIV    = 12'h004;
  localparam logic [11:0] OFF_STATUS = 12'h008;
  localparam logic [8:0]  DIV_RESET  = 9'h000;

  localparam int CTRL_EN_BIT      = 0;
  localparam int CTRL_MASTER_BIT  = 1;
  localparam int CTRL_RATIO_LSB   = 2;

  localparam logic [3:0] N_STD_LOW   = 4'h4;
  localparam logic [3:0] N_STD_HIGH  = 4'h4;
  localparam logic [3:0] N_ASYM_LOW  = 4'h6;
  localparam logic [3:0] N_ASYM_HIGH = 4'h3;
  localparam logic [3:0] N_FAST_LOW  = 4'hB;
  localparam logic [3:0] N_FAST_HIGH = 4'h6;

  localparam logic [5:0] HOLD_BASE = 6'h04;

  typedef struct packed {
    logic [5:0] low;
    logic [5:0] high;
  } phase_pair_s;

  // Low-divider table, index divider*3 + ratio
  localparam phase_pair_s SMALL_TABLE [9] = '{
    '{6'h07, 6'h07}, '{6'h09, 6'h06}, '{6'h0E, 6'h09},
    '{6'h0A, 6'h0A}, '{6'h0E, 6'h08}, '{6'h18, 6'h0E},
    '{6'h0F, 6'h0F}, '{6'h15, 6'h0C}, '{6'h24, 6'h15}};

  typedef struct packed {
    logic               en;
    logic               master;
    clock_ratio_select_e ratio;
    logic [8:0]         div;
    scl_state_e         state;
    logic [17:0]        count;
    logic [1:0]         sclSync;
    logic               sclDrive;
    logic [31:0]        prdata;
    logic               slaveReset;
  } state_s;

endpackage

// *** sim/scl_bus_peer.sv ***
`timescale 1ns/1ps
module scl_bus_peer (
  // Bus side
  input  wire logic       clk,
  input  wire logic       sclOe,
  input  wire logic [7:0] stretch,
  output logic            sclLine
);
  int hold = 0;
  always_ff @(posedge clk) begin
    if (sclOe) hold <= stretch;
    else if (hold > 0) hold <= hold - 1;
  end
  // Pull-up wins once nobody drives low
  assign sclLine = !(sclOe || hold > 0);
endmodule

// *** sim/test_i2c_scl_clock_generator.sv ***
`timescale 1ns/1ps
module test_i2c_scl_clock_generator;
  import scl_gen_pkg::*;
  logic        clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd, seed = 32'hA44A;
  logic        pready, pslverr, sclOut, sclOe, sclRun, slaveResetN, sclLine;
  logic [5:0]  maxHoldCycles;
  logic [7:0]  stretch = '0;
  int          mismatches = 0, comparisons = 0;
  int          tl[9] = '{7, 9, 14, 10, 14, 24, 15, 21, 36};
  int          th[9] = '{7, 6, 9, 10, 8, 14, 15, 12, 21};
  int          nl[3] = '{4, 6, 11};
  int          nh[3] = '{4, 3, 6};
  initial forever #2 clk = ~clk;
  scl_clock_gen dut (.clk(clk), .arst_n(arst_n), .clkEn(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sclIn(sclLine), .sclOut(sclOut), .sclOe(sclOe), .sclRun(sclRun),
    .maxHoldCycles(maxHoldCycles), .slaveResetN(slaveResetN));
  scl_bus_peer peer (.clk(clk), .sclOe(sclOe), .stretch(stretch), .sclLine(sclLine));
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic test_done();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input int lo, input int hi, input string m);
    comparisons++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      mismatches++;
      $display("wrong value at %0t: %s got %0d", $time, m, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk) penable <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 0;
    penable <= 0;
    if (n == 50) begin
      mismatches++;
      test_done();
    end else begin
      // Idle cycle keeps back-to-back calls from reassigning psel in one step
      @(posedge clk);
    end
  endtask
  task automatic rdreg(input logic [11:0] a);
    apb(0, a, 0);
  endtask
  task automatic phase(output int n, input bit line, input logic v);
    n = 0;
    while ((line ? sclLine : sclOe) === v && n < 3000) begin
      @(negedge clk);
      n++;
    end
    if (n == 3000) begin
      mismatches++;
      test_done();
    end
  endtask
  task automatic run(input int r, input int d, input int s);
    int el, eh, lo, hi, n;
    @(posedge clk);
    el = d < 3 ? tl[d*3+r] : nl[r] * (d + 1);
    eh = d < 3 ? th[d*3+r] : nh[r] * (d + 1);
    stretch <= 8'(s);
    // master mode only, so divider 0 is legal here
    apb(1, OFF_DIV, 32'(d));
    apb(1, OFF_CTRL, 32'(3 | r << 2));
    rdreg(OFF_DIV);
    chk(rd, d, d, "div");
    chk(32'(maxHoldCycles), 4 + d, 4 + d, "hold");
    // Let phases begun under the old setting finish
    for (int i = 0; i < 4; i++) phase(n, 0, 1'(i % 2 == 0));
    phase(lo, 0, 1);
    phase(n, 1, 0);
    phase(hi, 1, 1);
    chk(32'(lo), el, el, "low");
    chk(32'(hi), eh, eh + 3, "high");
    chk(32'(sclOut), 0, 0, "scl out");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    arst_n <= 1;
    @(posedge clk);
    rdreg(OFF_DIV);
    chk(rd, 0, 0, "div reset");
    rdreg(12'h0FC);
    chk(rd, 0, 0, "unmapped");
    for (int r = 0; r < 3; r++) begin
      for (int d = 0; d < 5; d++) begin
        seed = xs(seed);
        run(r, d == 4 ? 3 + int'(seed % 40) : d, d == 2 ? 5 : 0);
      end
    end
    @(posedge clk);
    // no address traffic on the bus while disabling
    apb(1, OFF_CTRL, 0);
    repeat (3) @(posedge clk);
    chk(32'(slaveResetN), 0, 0, "slave reset");
    chk(32'(sclOe | sclRun), 0, 0, "stopped");
    test_done();
  end
endmodule
